// File: src/ltc_top.sv
// limit trip controller: key editing, trip comparison, line monitor, safety
//
// Summary of operation
// R1: settings stay locked; edit mode only when both set keys pressed together
// R2: numeric display blinks while edit mode is active
// R3: in edit mode up key raises pending value, down key lowers it
// R4: holding up or down keeps stepping the pending value
// R5: edited value applies to comparison only after confirm key
// R6: confirm advances display: input, limit one, limit two, hysteresis
// R7: up and down together discard pending value, restore stored one
// R8: status code shows which parameter is displayed
// R9: lock jumper still allows display but rejects every change
// R10: contact select 0 gives low-limit action, 1 gives high-limit action
// R11: relays energized when not tripped
// R12: with line monitoring enabled a line fault acts on both relays
// R13: line fault below 3.5 mA equivalent or above 106.5 percent
// R14: underrange lamp lit while input below underrange limit
// R15: overrange lamp lit while input above overrange limit
// R16: live-zero select chooses dead-zero or 4 mA live-zero scaling
// R17: hysteresis editable when displayed; trip point centred in band
// R18: factory defaults: relay one high, relay two low, monitor on, live zero, 1 pct; reset loads only limits and hysteresis, the rest follows i_switch
// R19: any internal fault drives both relays to the safe state
// R20: relay readback supervised; watchdog forces relays off on mismatch
// R21: confirmed settings are kept in non-volatile storage
// R22: dead-man heartbeat supervised; a missed beat is a fault
// R23: relay one uses limit one, relay two limit two, shared hysteresis
// R24: keys are synchronized and debounced before use
`timescale 1ns/1ns
`default_nettype none

module ltc_top
#(
   parameter int DEBOUNCE = ltc_pkg::DEBOUNCE_CYC,
   parameter int REP_DLY  = ltc_pkg::REPEAT_DELAY_CYC,
   parameter int REP_RATE = ltc_pkg::REPEAT_RATE_CYC,
   parameter int BLINK    = ltc_pkg::BLINK_CYC,
   parameter int DEADMAN  = ltc_pkg::DEADMAN_CYC,
   parameter int COIL     = ltc_pkg::COIL_CYC
)
(
   // clock and reset
   input  wire logic                  i_mclk,
   input  wire logic                  i_rst_b,
   // front keys, switches, lock jumper
   input  wire ltc_pkg::ltc_keys_t    i_keys,
   input  wire ltc_pkg::ltc_switch_t  i_switch,
   input  wire logic                  i_lock_jumper,
   // measured input, one sample per strobe
   input  wire logic                  i_sample_vld,
   input  wire logic [9:0]            i_sample,
   // safety supervision
   input  wire logic                  i_heartbeat,
   input  wire logic                  i_internal_fault,
   input  wire logic [1:0]            i_relay_readback,
   // non-volatile store: restored settings at power-up
   input  wire logic                  i_nv_valid,
   input  wire ltc_pkg::ltc_setting_t i_nv_data,
   output ltc_pkg::ltc_setting_t      o_nv_data,
   output logic                       o_nv_write,
   // display
   output logic [9:0]                 o_display_value,
   output logic                       o_display_on,
   output ltc_pkg::ltc_param_t        o_status_code,
   output logic                       o_edit_active,
   // relays and lamps
   output logic [1:0]                 o_relay,
   output logic                       o_underrange_lamp,
   output logic                       o_overrange_lamp,
   output logic                       o_fault
);
   import ltc_pkg::*;

   // ----------------------------------------------------------------
   // key filtering
   // ----------------------------------------------------------------
   logic [4:0] k_lvl, k_prs, k_rep;

   genvar g;
   generate
      for (g = 0; g < 5; g++)
      begin : g_key
         ltc_key_filter #(.DEBOUNCE(DEBOUNCE), .DELAY(REP_DLY), .RATE(REP_RATE)) u_key
         (
            .i_mclk   (i_mclk),
            .i_rst_b  (i_rst_b),
            .i_key    (i_keys[g]),
            .o_level  (k_lvl[g]),
            .o_press  (k_prs[g]),
            .o_repeat (k_rep[g])
         ); // see R24
      end
   endgenerate

   // bit order follows ltc_keys_t: 4 set_a, 3 set_b, 2 up, 1 down, 0 step
   logic both_set, cancel_combo, up_ev, dn_ev, step_ev;
   assign both_set     = k_lvl[4] & k_lvl[3] & (k_prs[4] | k_prs[3]); // see R1
   assign cancel_combo = k_lvl[2] & k_lvl[1] & (k_prs[2] | k_prs[1]); // see R7
   assign up_ev        = (k_prs[2] | k_rep[2]) & ~k_lvl[1]; // see R4
   assign dn_ev        = (k_prs[1] | k_rep[1]) & ~k_lvl[2]; // see R4
   assign step_ev      = k_prs[0];

   // ----------------------------------------------------------------
   // settings and editing
   // ----------------------------------------------------------------
   ltc_setting_t set_r, set_nxt;
   logic [9:0]   pend_r, pend_nxt;
   logic         edit_r, edit_nxt;
   ltc_param_t   param_r, param_nxt;
   logic         nvw_r, nvw_nxt;
   logic         loaded_r, loaded_nxt;

   function automatic logic [9:0] stored(input ltc_setting_t s, input ltc_param_t p);
      unique case (p)
         FIRST_LIMIT_CODE:  stored = s.limit_one;
         SECOND_LIMIT_CODE: stored = s.limit_two;
         HYSTERESIS_CODE:   stored = s.hyst;
         INPUT_VALUE_CODE:  stored = 10'h000;
      endcase
   endfunction : stored

   always_comb
   begin
      set_nxt    = set_r;
      pend_nxt   = pend_r;
      edit_nxt   = edit_r;
      param_nxt  = param_r;
      nvw_nxt    = 1'b0;
      loaded_nxt = 1'b1;
      if (!loaded_r && i_nv_valid)
         set_nxt = i_nv_data; // see R21
      if (i_lock_jumper)
         edit_nxt = 1'b0; // see R9
      else if (both_set)
         edit_nxt = 1'b1; // see R1
      if (step_ev)
      begin
         // confirm commits the pending value, then moves on
         if (edit_r && !i_lock_jumper)
         begin
            unique case (param_r)
               FIRST_LIMIT_CODE:  set_nxt.limit_one = pend_r; // see R5
               SECOND_LIMIT_CODE: set_nxt.limit_two = pend_r; // see R5
               HYSTERESIS_CODE:   set_nxt.hyst      = pend_r; // see R17
               INPUT_VALUE_CODE:  set_nxt           = set_r;
            endcase
            nvw_nxt = (param_r != INPUT_VALUE_CODE); // see R21
         end
         param_nxt = ltc_param_t'(param_r + 2'h1); // see R6
         pend_nxt  = stored(set_nxt, ltc_param_t'(param_r + 2'h1));
      end
      else if (edit_r && !i_lock_jumper && param_r != INPUT_VALUE_CODE)
      begin
         if (cancel_combo)
            pend_nxt = stored(set_r, param_r); // see R7
         else if (up_ev && pend_r < VAL_MAX)
            pend_nxt = pend_r + 10'h001; // see R3
         else if (dn_ev && pend_r != 10'h000)
            pend_nxt = pend_r - 10'h001; // see R3
      end
      if (!edit_r)
         pend_nxt = stored(set_nxt, param_nxt);
   end

   always_ff @(posedge i_mclk)
   begin
      if (!i_rst_b)
      begin
         set_r    <= '{DEF_LIMIT_ONE, DEF_LIMIT_TWO, DEF_HYST}; // see R18
         pend_r   <= 10'h000;
         edit_r   <= 1'b0;
         param_r  <= INPUT_VALUE_CODE;
         nvw_r    <= 1'b0;
         loaded_r <= 1'b0;
      end
      else
      begin
         set_r    <= set_nxt;
         pend_r   <= pend_nxt;
         edit_r   <= edit_nxt;
         param_r  <= param_nxt;
         nvw_r    <= nvw_nxt;
         loaded_r <= loaded_nxt;
      end
   end

   // ----------------------------------------------------------------
   // scaling, comparison, line monitor
   // ----------------------------------------------------------------
   logic [9:0]  samp_r, samp_nxt;
   logic [9:0]  scaled;
   logic [1:0]  trip_r, trip_nxt;
   logic        under_r, under_nxt, over_r, over_nxt;
   logic [10:0] lo_edge [2];
   logic [10:0] hi_edge [2];
   logic [9:0]  lim [2];
   logic [1:0]  csel;

   assign lim[0] = set_r.limit_one; // see R23
   assign lim[1] = set_r.limit_two; // see R23
   assign csel   = {i_switch.relay_two_contact_select, i_switch.relay_one_contact_select};

   // live zero removes the offset and stretches the span back to full scale
   always_comb
   begin
      logic [19:0] prod;
      prod = 20'h0;
      if (!i_switch.live_zero_select)
         scaled = samp_r; // see R16
      else if (samp_r <= LIVE_OFFSET)
         scaled = 10'h000; // see R16
      else
      begin
         prod   = 20'(samp_r - LIVE_OFFSET) * 20'(FULL_SCALE) / 20'(FULL_SCALE - LIVE_OFFSET);
         scaled = (prod > 20'(VAL_MAX)) ? VAL_MAX : prod[9:0]; // see R16
      end
   end

   generate
      for (g = 0; g < 2; g++)
      begin : g_band
         // band edges at half the hysteresis on each side of the limit
         assign hi_edge[g] = {1'b0, lim[g]} + {2'b00, set_r.hyst[9:1]}; // see R17
         assign lo_edge[g] = ({1'b0, lim[g]} > {2'b00, set_r.hyst[9:1]}) ?
                             ({1'b0, lim[g]} - {2'b00, set_r.hyst[9:1]}) : 11'h000;
      end
   endgenerate

   always_comb
   begin
      samp_nxt  = i_sample_vld ? i_sample : samp_r;
      trip_nxt  = trip_r;
      under_nxt = samp_r < UNDER_LIMIT; // see R13
      over_nxt  = samp_r > OVER_LIMIT; // see R13
      for (int i = 0; i < 2; i++)
      begin
         if (csel[i])
         begin
            // high limit: trip above upper edge, release below lower edge
            if ({1'b0, scaled} > hi_edge[i])
               trip_nxt[i] = 1'b1; // see R10
            else if ({1'b0, scaled} < lo_edge[i])
               trip_nxt[i] = 1'b0;
         end
         else
         begin
            if ({1'b0, scaled} < lo_edge[i])
               trip_nxt[i] = 1'b1; // see R10
            else if ({1'b0, scaled} > hi_edge[i])
               trip_nxt[i] = 1'b0;
         end
      end
   end

   always_ff @(posedge i_mclk)
   begin
      if (!i_rst_b)
      begin
         samp_r  <= 10'h000;
         trip_r  <= 2'h0;
         under_r <= 1'b0;
         over_r  <= 1'b0;
      end
      else
      begin
         samp_r  <= samp_nxt;
         trip_r  <= trip_nxt;
         under_r <= under_nxt;
         over_r  <= over_nxt;
      end
   end

   // ----------------------------------------------------------------
   // safety: dead-man, coil supervision, blink, outputs
   // ----------------------------------------------------------------
   logic [26:0] dm_cnt_r, dm_cnt_nxt;
   logic [26:0] coil_cnt_r, coil_cnt_nxt;
   logic [26:0] blk_cnt_r, blk_cnt_nxt;
   logic        hb_r, hb_nxt;
   logic        fault_r, fault_nxt;
   logic        blink_r, blink_nxt;
   logic [1:0]  relay_r, relay_nxt;
   logic        line_fault;
   logic [9:0]  disp_nxt, disp_r;

   assign line_fault = i_switch.line_monitor_enable & (under_r | over_r); // see R12

   always_comb
   begin
      hb_nxt       = i_heartbeat;
      fault_nxt    = fault_r | i_internal_fault; // see R19
      dm_cnt_nxt   = dm_cnt_r + 27'h1;
      coil_cnt_nxt = 27'h0;
      blk_cnt_nxt  = blk_cnt_r + 27'h1;
      blink_nxt    = blink_r;
      // any heartbeat edge restarts the dead-man window
      if (hb_r != i_heartbeat)
         dm_cnt_nxt = 27'h0;
      else if (dm_cnt_r >= 27'(DEADMAN - 1))
      begin
         dm_cnt_nxt = dm_cnt_r;
         fault_nxt  = 1'b1; // see R22
      end
      // readback must follow the drive within the coil settle time
      if (i_relay_readback != relay_r)
      begin
         coil_cnt_nxt = coil_cnt_r + 27'h1;
         if (coil_cnt_r >= 27'(COIL - 1))
         begin
            coil_cnt_nxt = coil_cnt_r;
            fault_nxt    = 1'b1; // see R20
         end
      end
      if (blk_cnt_r >= 27'(BLINK - 1))
      begin
         blk_cnt_nxt = 27'h0;
         blink_nxt   = ~blink_r;
      end
      // energized while normal; a fault latches both relays off
      relay_nxt = ~trip_r; // see R11
      if (line_fault)
         relay_nxt = 2'b00; // see R12
      if (fault_r)
         relay_nxt = 2'b00; // see R19
      disp_nxt = (param_r == INPUT_VALUE_CODE) ? scaled : pend_r; // see R9
   end

   always_ff @(posedge i_mclk)
   begin
      if (!i_rst_b)
      begin
         dm_cnt_r   <= 27'h0;
         coil_cnt_r <= 27'h0;
         blk_cnt_r  <= 27'h0;
         hb_r       <= 1'b0;
         fault_r    <= 1'b0;
         blink_r    <= 1'b0;
         relay_r    <= 2'b00;
         disp_r     <= 10'h000;
      end
      else
      begin
         dm_cnt_r   <= dm_cnt_nxt;
         coil_cnt_r <= coil_cnt_nxt;
         blk_cnt_r  <= blk_cnt_nxt;
         hb_r       <= hb_nxt;
         fault_r    <= fault_nxt;
         blink_r    <= blink_nxt;
         relay_r    <= relay_nxt;
         disp_r     <= disp_nxt;
      end
   end

   assign o_relay           = relay_r;
   assign o_fault           = fault_r;
   assign o_underrange_lamp = under_r; // see R14
   assign o_overrange_lamp  = over_r; // see R15
   assign o_display_value   = disp_r;
   assign o_display_on      = ~(edit_r & blink_r); // see R2
   assign o_status_code     = param_r; // see R8
   assign o_edit_active     = edit_r;
   assign o_nv_data         = set_r;
   assign o_nv_write        = nvw_r;

endmodule : ltc_top

`default_nettype wire

// File: src/ltc_pkg.sv
// package for the limit trip controller: constants, codes and carrier types
package ltc_pkg;

   // ----------------------------------------------------------------
   // measurement scale
   // ----------------------------------------------------------------
   // 1000 points span 0..22 mA
   localparam int         VAL_W = 10;
   localparam logic [9:0] VAL_MAX = 10'h3E8;
   // live-zero offset 4 mA / 1 V / 2 V = 182 points
   localparam logic [9:0] LIVE_OFFSET = 10'h0B6;
   // underrange 3.5 mA = 159 points
   localparam logic [9:0] UNDER_LIMIT = 10'h09F;
   // overrange 106.5 % of the 4..20 mA span = 21.04 mA = 956 points
   localparam logic [9:0] OVER_LIMIT = 10'h3BC;
   // full scale 20 mA = 909 points
   localparam logic [9:0] FULL_SCALE = 10'h38D;

   // ----------------------------------------------------------------
   // factory defaults
   // ----------------------------------------------------------------
   localparam logic [9:0] DEF_LIMIT_ONE = 10'h320;
   localparam logic [9:0] DEF_LIMIT_TWO = 10'h0C8;
   // about 1 percent of range
   localparam logic [9:0] DEF_HYST = 10'h00A;
   localparam logic       DEF_RELAY_ONE_SEL = 1'b1;
   localparam logic       DEF_RELAY_TWO_SEL = 1'b0;
   localparam logic       DEF_LINE_MON = 1'b1;
   localparam logic       DEF_LIVE_ZERO = 1'b1;

   // ----------------------------------------------------------------
   // timing (clock 125 MHz)
   // ----------------------------------------------------------------
   localparam int         CLK_HZ = 125_000_000;
   localparam int         DEBOUNCE_MS = 10;
   localparam int         DEBOUNCE_CYC = CLK_HZ / 1000 * DEBOUNCE_MS;
   localparam int         REPEAT_DELAY_MS = 500;
   localparam int         REPEAT_DELAY_CYC = CLK_HZ / 1000 * REPEAT_DELAY_MS;
   localparam int         REPEAT_RATE_MS = 100;
   localparam int         REPEAT_RATE_CYC = CLK_HZ / 1000 * REPEAT_RATE_MS;
   localparam int         BLINK_MS = 250;
   localparam int         BLINK_CYC = CLK_HZ / 1000 * BLINK_MS;
   localparam int         DEADMAN_MS = 100;
   localparam int         DEADMAN_CYC = CLK_HZ / 1000 * DEADMAN_MS;
   localparam int         COIL_MS = 20;
   localparam int         COIL_CYC = CLK_HZ / 1000 * COIL_MS;

   // ----------------------------------------------------------------
   // displayed parameter codes
   // ----------------------------------------------------------------
   typedef enum logic [1:0]
   {
      INPUT_VALUE_CODE  = 2'h0,
      FIRST_LIMIT_CODE  = 2'h1,
      SECOND_LIMIT_CODE = 2'h2,
      HYSTERESIS_CODE   = 2'h3
   } ltc_param_t;

   // ----------------------------------------------------------------
   // carriers
   // ----------------------------------------------------------------
   typedef struct packed
   {
      logic set_a;
      logic set_b;
      logic up;
      logic down;
      logic step;
   } ltc_keys_t;

   typedef struct packed
   {
      logic relay_one_contact_select;
      logic relay_two_contact_select;
      logic line_monitor_enable;
      logic live_zero_select;
   } ltc_switch_t;

   typedef struct packed
   {
      logic [9:0] limit_one;
      logic [9:0] limit_two;
      logic [9:0] hyst;
   } ltc_setting_t;

endpackage : ltc_pkg

// File: src/ltc_key_filter.sv
// one debounced key with hold-repeat pulse generation
`timescale 1ns/1ns
`default_nettype none

module ltc_key_filter
#(
   parameter int DEBOUNCE = 1250000,
   parameter int DELAY    = 62500000,
   parameter int RATE     = 12500000
)
(
   // clock and reset
   input  wire logic i_mclk,
   input  wire logic i_rst_b,
   // raw key level
   input  wire logic i_key,
   // filtered level, press pulse, repeat pulse
   output logic      o_level,
   output logic      o_press,
   output logic      o_repeat
);

   logic        sync1_r, sync2_r, sync1_nxt, sync2_nxt;
   logic        level_r, level_nxt;
   logic        press_r, press_nxt;
   logic        rep_r, rep_nxt;
   logic [26:0] db_cnt_r, db_cnt_nxt;
   logic [26:0] hold_cnt_r, hold_cnt_nxt;
   logic        first_r, first_nxt;

   always_comb
   begin
      sync1_nxt    = i_key;
      sync2_nxt    = sync1_r;
      level_nxt    = level_r;
      press_nxt    = 1'b0;
      rep_nxt      = 1'b0;
      db_cnt_nxt   = db_cnt_r;
      hold_cnt_nxt = hold_cnt_r;
      first_nxt    = first_r;
      // accept a level only after a full debounce time
      if (sync2_r == level_r)
         db_cnt_nxt = '0;
      else if (db_cnt_r >= 27'(DEBOUNCE - 1))
      begin
         db_cnt_nxt = '0;
         level_nxt  = sync2_r;
         press_nxt  = sync2_r;
      end
      else
         db_cnt_nxt = db_cnt_r + 27'h1;
      // hold repeat: first a long delay, then a faster cadence
      if (!level_r)
      begin
         hold_cnt_nxt = '0;
         first_nxt    = 1'b1;
      end
      else if (hold_cnt_r >= (first_r ? 27'(DELAY - 1) : 27'(RATE - 1)))
      begin
         hold_cnt_nxt = '0;
         first_nxt    = 1'b0;
         rep_nxt      = 1'b1;
      end
      else
         hold_cnt_nxt = hold_cnt_r + 27'h1;
   end

   always_ff @(posedge i_mclk)
   begin
      if (!i_rst_b)
      begin
         sync1_r    <= 1'b0;
         sync2_r    <= 1'b0;
         level_r    <= 1'b0;
         press_r    <= 1'b0;
         rep_r      <= 1'b0;
         db_cnt_r   <= '0;
         hold_cnt_r <= '0;
         first_r    <= 1'b1;
      end
      else
      begin
         sync1_r    <= sync1_nxt;
         sync2_r    <= sync2_nxt;
         level_r    <= level_nxt;
         press_r    <= press_nxt;
         rep_r      <= rep_nxt;
         db_cnt_r   <= db_cnt_nxt;
         hold_cnt_r <= hold_cnt_nxt;
         first_r    <= first_nxt;
      end
   end

   assign o_level  = level_r;
   assign o_press  = press_r;
   assign o_repeat = rep_r;

endmodule : ltc_key_filter

`default_nettype wire

// File: testbench/ltc_xmtr_model.sv
// field transmitter model: one measurement word per request
`timescale 1ns/1ns
`default_nettype none

module ltc_xmtr_model
(
   // clock
   input  wire logic       i_mclk,
   // request from the bench
   input  wire logic       i_req,
   input  wire logic [9:0] i_level,
   // word towards the device
   output var logic        o_vld,
   output var logic [9:0]  o_sample
);
   initial o_vld = 1'b0;
   initial o_sample = 10'h000;

   // outside the strobe the word inverts on every cycle, so a late sample fails
   always @(posedge i_mclk)
   begin
      o_vld    <= i_req;
      o_sample <= i_req ? i_level : ~o_sample;
   end
endmodule : ltc_xmtr_model

`default_nettype wire

// File: testbench/ltc_top_asserts.sv
// port-level assertions for the limit trip controller
`timescale 1ns/1ns
`default_nettype none

module ltc_top_asserts
   import ltc_pkg::*;
(
   // clock, reset and inputs
   input wire logic                 i_mclk,
   input wire logic                 i_rst_b,
   input wire ltc_pkg::ltc_switch_t i_switch,
   input wire logic                 i_lock_jumper,
   input wire logic                 i_sample_vld,
   input wire logic [9:0]           i_sample,
   input wire logic                 i_internal_fault,
   // outputs
   input wire logic                 o_nv_write,
   input wire logic                 o_display_on,
   input wire logic                 o_edit_active,
   input wire logic [1:0]           o_relay,
   input wire logic                 o_underrange_lamp,
   input wire logic                 o_overrange_lamp,
   input wire logic                 o_fault
);
   default clocking cb @(posedge i_mclk); endclocking
   default disable iff (!i_rst_b);

   chk_lamp_under: assert property (
      i_sample_vld |-> ##2 (o_underrange_lamp == ($past(i_sample, 2) < UNDER_LIMIT)))
      else $error("underrange lamp wrong");
   chk_lamp_over: assert property (
      i_sample_vld |-> ##2 (o_overrange_lamp == ($past(i_sample, 2) > OVER_LIMIT)))
      else $error("overrange lamp wrong");
   chk_line_trip: assert property (
      (i_switch.line_monitor_enable && (o_underrange_lamp || o_overrange_lamp)) [*3] |-> (o_relay == 2'h0))
      else $error("line fault left a relay energized");
   chk_fault_latch: assert property (
      i_internal_fault |-> ##[1:2] o_fault)
      else $error("internal fault not flagged");
   chk_fault_safe: assert property (
      o_fault |-> ##2 (o_relay == 2'h0))
      else $error("relay energized under fault");
   chk_lock_edit: assert property (
      i_lock_jumper [*2] |-> !o_edit_active)
      else $error("edit mode while locked");
   chk_lock_nv: assert property (
      i_lock_jumper [*2] |-> !o_nv_write)
      else $error("setting stored while locked");
   chk_nv_pulse: assert property (
      o_nv_write |=> !o_nv_write)
      else $error("store strobe longer than one cycle");
   chk_blink_idle: assert property (
      !o_edit_active [*3] |-> o_display_on)
      else $error("display blanked outside edit mode");
   chk_reset_relay: assert property (disable iff (1'b0)
      !i_rst_b |=> (o_relay == 2'h0))
      else $error("relay energized in reset");

   cov_edit: cover property (o_edit_active && !o_display_on);
   cov_store: cover property (o_nv_write);
   cov_fault: cover property (o_fault);
   cov_line: cover property (i_switch.line_monitor_enable && o_underrange_lamp);
endmodule : ltc_top_asserts

bind ltc_top ltc_top_asserts u_ltc_top_asserts (.*);

`default_nettype wire

// File: testbench/testbench.sv
// self-checking bench for the limit trip controller
`timescale 1ns/1ns
`default_nettype none
`define CHK(n, e, s) begin total_checks++; if ((s) !== (e)) begin err_total++; \
   $display("ERROR %s expected %0h seen %0h", n, e, s); end end

module testbench;
   import ltc_pkg::*;
   logic         i_mclk = 1'b0;
   logic         i_rst_b = 1'b0;
   ltc_keys_t    keys = '0;
   ltc_switch_t  sw = '0;
   logic         lock = 1'b0, req = 1'b0, hb = 1'b0, flt = 1'b0, hb_en = 1'b1, rb_bad = 1'b0, nv_v = 1'b0;
   logic [9:0]   lvl = '0, pend, smp, disp;
   logic [1:0]   rb = '0, rel, tr;
   logic         vld, nvw, don, edit, ul, ol, fault;
   ltc_setting_t nv_q, nv_d = '0;
   ltc_param_t   code;
   logic [31:0]  seed = 32'h2CEA;
   int           err_total = 0, total_checks = 0, hb_cnt = 0, nw_cnt = 0, n;
   logic [9:0]   corner [14] = '{10'h1F4, 10'h09E, 10'h09F, 10'h3BC, 10'h3BD, 10'h31A, 10'h31B,
                                 10'h325, 10'h326, 10'h0C2, 10'h0C3, 10'h0CE, 10'h000, 10'h3E8};

   always #4 i_mclk = ~i_mclk;

   // readback trails the coils by a cycle; rb_bad stages a coil fault
   always @(posedge i_mclk)
   begin
      rb <= rb_bad ? ~rel : rel;
      hb_cnt <= hb_cnt + 1;
      if (hb_en && hb_cnt % 50 == 0)
         hb <= ~hb;
      if (nvw === 1'b1)
         nw_cnt <= nw_cnt + 1;
   end

   ltc_top #(.DEBOUNCE(4), .REP_DLY(20), .REP_RATE(5), .BLINK(8), .DEADMAN(200), .COIL(10)) u_ltc_top (
      .i_mclk, .i_rst_b, .i_keys(keys), .i_switch(sw), .i_lock_jumper(lock), .i_sample_vld(vld),
      .i_sample(smp), .i_heartbeat(hb), .i_internal_fault(flt), .i_relay_readback(rb),
      .i_nv_valid(nv_v), .i_nv_data(nv_d), .o_nv_data(nv_q), .o_nv_write(nvw), .o_display_value(disp),
      .o_display_on(don), .o_status_code(code), .o_edit_active(edit), .o_relay(rel),
      .o_underrange_lamp(ul), .o_overrange_lamp(ol), .o_fault(fault));
   ltc_xmtr_model u_ltc_xmtr_model (.i_mclk, .i_req(req), .i_level(lvl), .o_vld(vld), .o_sample(smp));

   function automatic logic [31:0] xs(input logic [31:0] x);
      x ^= x << 13;
      x ^= x >> 17;
      x ^= x << 5;
      return x;
   endfunction : xs

   // band centred on the limit; inside it the state holds
   function automatic logic trip_nxt(input int v, input int lim, input logic hi, input logic st);
      if (hi)
         return (v > lim + DEF_HYST / 2) ? 1'b1 : (v < lim - DEF_HYST / 2) ? 1'b0 : st;
      return (v < lim - DEF_HYST / 2) ? 1'b1 : (v > lim + DEF_HYST / 2) ? 1'b0 : st;
   endfunction : trip_nxt

   task automatic send(input logic [9:0] v);
      int s;
      @(posedge i_mclk);
      req <= 1'b1;
      lvl <= v;
      @(posedge i_mclk);
      req <= 1'b0;
      s = !sw.live_zero_select ? v : (v <= LIVE_OFFSET) ? 0 : (v - LIVE_OFFSET) * FULL_SCALE / (FULL_SCALE - LIVE_OFFSET);
      tr[0] = trip_nxt(s, DEF_LIMIT_ONE, sw.relay_one_contact_select, tr[0]);
      tr[1] = trip_nxt(s, DEF_LIMIT_TWO, sw.relay_two_contact_select, tr[1]);
      repeat (6) @(posedge i_mclk);
      #1;
      `CHK("underrange lamp", v < UNDER_LIMIT, ul)
      `CHK("overrange lamp", v > OVER_LIMIT, ol)
      `CHK("relays", (sw.line_monitor_enable && (v < UNDER_LIMIT || v > OVER_LIMIT)) ? 2'h0 : ~tr, rel)
   endtask : send

   task automatic press(input ltc_keys_t k, input int hold);
      @(posedge i_mclk);
      keys <= k;
      repeat (hold) @(posedge i_mclk);
      keys <= '0;
      repeat (12) @(posedge i_mclk);
      #1;
   endtask : press

   task automatic print_verdict();
      $display("checks %0d errors %0d", total_checks, err_total);
      if (err_total == 0 && total_checks > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask : print_verdict

   initial
   begin
      repeat (8) @(posedge i_mclk);
      i_rst_b <= 1'b1;
      #1;
      `CHK("reset relays", 2'h0, rel)
      `CHK("defaults", {DEF_LIMIT_ONE, DEF_LIMIT_TWO, DEF_HYST}, nv_q)
      `CHK("reset code", INPUT_VALUE_CODE, code)
      $display("test reset done");
      // all contact selections, then line monitoring, then live zero
      for (int c = 0; c < 6; c++)
      begin
         @(posedge i_mclk);
         sw <= {c[1:0], c[2], c == 5};
         for (int i = 0; i < 24; i++)
         begin
            seed = xs(seed);
            send(i < 14 ? corner[i] : 10'(seed % 1001));
         end
      end
      $display("test trip done");
      press(5'h01, 12);
      `CHK("code step", FIRST_LIMIT_CODE, code)
      `CHK("locked", 1'b0, edit)
      `CHK("no store", 0, nw_cnt)
      press(5'h18, 12);
      `CHK("edit entry", 1'b1, edit)
      n = 0;
      repeat (30)
      begin
         @(posedge i_mclk);
         if (don === 1'b0)
            n++;
      end
      `CHK("blink", 1'b1, n > 0 && n < 30)
      press(5'h04, 12);
      `CHK("pending up", 10'h321, disp)
      press(5'h06, 12);
      `CHK("cancel", 10'h320, disp)
      press(5'h04, 50);
      `CHK("hold repeat", 1'b1, disp > 10'h322)
      `CHK("old limit", 10'h320, nv_q.limit_one)
      pend = disp;
      press(5'h01, 12);
      `CHK("commit", pend, nv_q.limit_one)
      `CHK("one store", 1, nw_cnt)
      `CHK("code two", SECOND_LIMIT_CODE, code)
      press(5'h01, 12);
      press(5'h18, 12);
      press(5'h02, 12);
      `CHK("hyst down", 10'h009, disp)
      press(5'h01, 12);
      `CHK("hyst store", 10'h009, nv_q.hyst)
      `CHK("code wrap", INPUT_VALUE_CODE, code)
      $display("test edit done");
      @(posedge i_mclk);
      lock <= 1'b1;
      press(5'h18, 12);
      `CHK("lock edit", 1'b0, edit)
      press(5'h01, 12);
      `CHK("lock view", FIRST_LIMIT_CODE, code)
      @(posedge i_mclk);
      lock <= 1'b0;
      $display("test lock done");
      // internal fault, missed heartbeat, coil readback mismatch
      for (int k = 0; k < 3; k++)
      begin
         @(posedge i_mclk);
         i_rst_b <= 1'b0;
         flt <= 1'b0;
         hb_en <= 1'b1;
         rb_bad <= 1'b0;
         nv_v <= 1'b1;
         nv_d <= seed[29:0];
         repeat (3) @(posedge i_mclk);
         i_rst_b <= 1'b1;
         repeat (3) @(posedge i_mclk);
         #1;
         `CHK("fault clear", 1'b0, fault)
         `CHK("restore", nv_d, nv_q)
         @(posedge i_mclk);
         flt <= (k == 0);
         hb_en <= (k != 1);
         rb_bad <= (k == 2);
         repeat (300) @(posedge i_mclk);
         #1;
         `CHK("fault set", 1'b1, fault)
         `CHK("fault relays", 2'h0, rel)
      end
      $display("test fault done");
      print_verdict();
   end

   initial
   begin
      repeat (100000) @(posedge i_mclk);
      err_total++;
      print_verdict();
   end
endmodule : testbench

`default_nettype wire
